// ---- rtl/srs_master_end.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Receive buffer between the master's shifter and its user.
// ****************************************************************
module srs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst,
  // Filling side.
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // Draining side.
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             count;
  } srs_fifo_t;

  srs_fifo_t r;
  srs_fifo_t next_r;
  logic      push;
  logic      pop;

  // Pointers wrap at the depth, which need not be a power of two.
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign inReady  = (r.count != (AW + 1)'(DEPTH));
  assign outValid = (r.count != '0);
  assign outData  = r.mem[r.rd];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Push and pop may happen together; the count then stands.
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr] = inData;
      next_r.wr        = bump(r.wr);
    end
    if (pop) begin
      next_r.rd = bump(r.rd);
    end
    if (push && !pop) begin
      next_r.count = r.count + (AW + 1)'(1);
    end else if (pop && !push) begin
      next_r.count = r.count - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ****************************************************************
// Master end: issues the read sequence and collects the data.
// ****************************************************************
module srs_master_end (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Serial bus.
  srs_bus_if.master        bus,
  // Read request; length is byte count minus one.
  input  wire logic        reqValid,
  input  wire logic [10:0] reqAddr,
  input  wire logic [7:0]  reqLen,
  // Status.
  output logic             busy,
  output logic             done,
  output logic             nackSeen,
  // Received data.
  output logic             dataValid,
  output logic [7:0]       data,
  input  wire logic        dataReady
);

  typedef struct packed {
    srs_pkg::srs_mst_state_t st;
    logic [1:0]              q;
    logic [8:0]              timer;
    logic [3:0]              bitCnt;
    logic [7:0]              txByte;
    logic [7:0]              rxByte;
    logic [1:0]              seq;
    logic [7:0]              left;
    logic [10:0]             loc;
    logic                    ackOk;
    logic                    sclOe;
    logic                    sdaOe;
    logic                    pushValid;
    logic                    pushDone;
    logic                    busy;
    logic                    done;
    logic                    nack;
  } srs_mst_t;

  srs_mst_t r;
  srs_mst_t next_r;
  logic     fifoReady;
  logic     isRead;

  assign isRead = (r.seq == 2'h3);

  // Received bytes wait here; a full buffer holds the clock low.
  srs_fifo #(
    .W     (srs_pkg::BYTE_W),
    .DEPTH (srs_pkg::FIFO_DEPTH)
  ) rxFifo (
    .clock    (clock),
    .rst      (rst),
    .inValid  (r.pushValid),
    .inData   (r.rxByte),
    .inReady  (fifoReady),
    .outValid (dataValid),
    .outData  (data),
    .outReady (dataReady)
  );

  // Each bit is four quarter steps: set data, raise, sample, lower.
  always_comb begin
    next_r           = r;
    next_r.done      = 1'b0;
    next_r.pushValid = 1'b0;
    if (r.st == srs_pkg::MST_IDLE) begin
      if (reqValid) begin
        next_r.st     = srs_pkg::MST_START;
        next_r.loc    = reqAddr;
        next_r.left   = reqLen;
        next_r.seq    = 2'h0;
        next_r.txByte = {srs_pkg::ID_PREFIX, reqAddr[10:8],
                         srs_pkg::DIR_WRITE};
        next_r.busy   = 1'b1;
        next_r.nack   = 1'b0;
        next_r.q      = srs_pkg::STEP_RESET;
        next_r.timer  = srs_pkg::QUARTER_LOAD;
      end
    end else if (r.timer != 9'h000) begin
      next_r.timer = r.timer - 9'h001;
    end else begin
      next_r.timer = srs_pkg::QUARTER_LOAD;
      next_r.q     = r.q + 2'h1;
      case (r.st)
        srs_pkg::MST_START: begin
          // Data falls while the clock is high: a (repeated) START.
          case (r.q)
            2'h0: next_r.sdaOe = 1'b0;
            2'h1: next_r.sclOe = 1'b0;
            2'h2: next_r.sdaOe = 1'b1;
            default: begin
              next_r.sclOe  = 1'b1;
              next_r.bitCnt = 4'h0;
              next_r.st     = srs_pkg::MST_BIT;
            end
          endcase
        end
        srs_pkg::MST_BIT: begin
          case (r.q)
            2'h0: begin
              if (r.bitCnt != srs_pkg::ACK_SLOT) begin
                next_r.sdaOe = isRead ? 1'b0 : !r.txByte[7];
              end else if (!isRead) begin
                next_r.sdaOe = 1'b0;
              end else if (!r.pushDone) begin
                // Stall here, clock low, until the buffer takes it.
                next_r.q     = r.q;
                next_r.timer = 9'h000;
                if (fifoReady) begin
                  next_r.pushValid = 1'b1;
                  next_r.pushDone  = 1'b1;
                end
              end else begin
                next_r.sdaOe = (r.left != 8'h00);
              end
            end
            2'h1: next_r.sclOe = 1'b0;
            2'h2: begin
              if (r.bitCnt == srs_pkg::ACK_SLOT) begin
                next_r.ackOk = !bus.sda;
              end else if (isRead) begin
                next_r.rxByte = {r.rxByte[6:0], bus.sda};
              end
            end
            default: begin
              next_r.sclOe    = 1'b1;
              next_r.pushDone = 1'b0;
              next_r.txByte   = {r.txByte[6:0], 1'b0};
              next_r.bitCnt   = r.bitCnt + 4'h1;
              if (r.bitCnt == srs_pkg::ACK_SLOT) begin
                next_r.bitCnt = 4'h0;
                if (!isRead && !r.ackOk) begin
                  next_r.nack = 1'b1;
                  next_r.st   = srs_pkg::MST_STOP;
                end else if (r.seq == 2'h0) begin
                  next_r.seq    = 2'h1;
                  next_r.txByte = r.loc[7:0];
                end else if (r.seq == 2'h1) begin
                  next_r.seq    = 2'h2;
                  next_r.txByte = {srs_pkg::ID_PREFIX, r.loc[10:8],
                                   srs_pkg::DIR_READ};
                  next_r.st     = srs_pkg::MST_START;
                end else if (r.seq == 2'h2) begin
                  next_r.seq = 2'h3;
                end else if (r.left == 8'h00) begin
                  next_r.st = srs_pkg::MST_STOP;
                end else begin
                  next_r.left = r.left - 8'h01;
                end
              end
            end
          endcase
        end
        srs_pkg::MST_STOP: begin
          // Data rises while the clock is high: STOP.
          case (r.q)
            2'h0: next_r.sdaOe = 1'b1;
            2'h1: next_r.sclOe = 1'b0;
            2'h2: next_r.sdaOe = 1'b0;
            default: begin
              next_r.st   = srs_pkg::MST_IDLE;
              next_r.busy = 1'b0;
              next_r.done = 1'b1;
            end
          endcase
        end
        default: begin
          next_r.st    = srs_pkg::MST_IDLE;
          next_r.sclOe = 1'b0;
          next_r.sdaOe = 1'b0;
          next_r.busy  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r       <= '0;
      r.st    <= srs_pkg::MST_IDLE;
      r.timer <= srs_pkg::TIMER_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign bus.masterSclOe = r.sclOe;
  assign bus.masterSdaOe = r.sdaOe;
  assign busy            = r.busy;
  assign done            = r.done;
  assign nackSeen        = r.nack;

endmodule

// ---- rtl/srs_pkg.sv ----
// ****************************************************************
// Shared constants and types of the serial memory read sequencer.
// ****************************************************************
package srs_pkg;

  // ****************************************************************
  // Location space and byte format.
  // ****************************************************************
  localparam int          LOC_W      = 11;
  localparam int          MEM_BYTES  = 2048;
  localparam int          BYTE_W     = 8;
  localparam int          UPPER_W    = 3;
  localparam logic [10:0] WIPER_LOC  = 11'h7ff;
  // Identification prefix; the value is arbitrary.
  localparam logic [3:0]  ID_PREFIX  = 4'h6;
  localparam logic        DIR_WRITE  = 1'h0;
  localparam logic        DIR_READ   = 1'h1;
  localparam logic [3:0]  ACK_SLOT   = 4'h8;

  // ****************************************************************
  // Buffering between the master's receiver and its user.
  // ****************************************************************
  localparam int          FIFO_DEPTH = 4;

  // ****************************************************************
  // Serial clock timing: 10 us period, four quarter steps per bit.
  // ****************************************************************
  localparam int          CLOCK_PERIOD_NS = 8;
  localparam int          SCL_PERIOD_NS   = 10000;
  localparam int          QUARTER_CYCLES  =
    (SCL_PERIOD_NS / 4 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [8:0]  QUARTER_LOAD    = 9'(QUARTER_CYCLES - 1);

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [8:0]  TIMER_RESET = 9'h000;
  localparam logic [1:0]  STEP_RESET  = 2'h0;

  // ****************************************************************
  // State encodings.
  // ****************************************************************
  typedef enum logic [5:0] {
    DEV_IDLE   = 6'h01,
    DEV_RXID   = 6'h02,
    DEV_RXADDR = 6'h04,
    DEV_ACKOUT = 6'h08,
    DEV_TX     = 6'h10,
    DEV_ACKIN  = 6'h20
  } srs_dev_state_t;

  typedef enum logic [3:0] {
    MST_IDLE  = 4'h1,
    MST_START = 4'h2,
    MST_BIT   = 4'h4,
    MST_STOP  = 4'h8
  } srs_mst_state_t;

endpackage

// ---- rtl/srs_bus_if.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Two-wire bus: open-drain lines resolved from the output enables.
// ****************************************************************
interface srs_bus_if;
  logic masterSclOe;
  logic masterSdaOe;
  logic deviceSdaOe;
  logic scl;
  logic sda;

  // A line is low whenever any party pulls it, high otherwise.
  assign scl = ~masterSclOe;
  assign sda = ~(masterSdaOe | deviceSdaOe);

  modport device (input scl, input sda, output deviceSdaOe);
  modport master (input scl, input sda, output masterSclOe,
                  output masterSdaOe);
endinterface

// ---- rtl/srs_device_end.sv ----
`timescale 1ns/1ps
// Function
// - Master opens with START, write ID, address.
// - Repeated START, then read ID, same bits.
// - Device acknowledges all three instruction bytes.
// - Keep sending while master acknowledges each byte.
// - Master ends read with STOP.
// - Pointer starts at ID upper bits plus address.
// - Pointer advances one per transmitted byte.
// - Eleven-bit location, three upper, eight lower.
// - Bytes travel most significant bit first.
// - Location 7FF returns a wiper value by select.

// ****************************************************************
// Device end: slave that answers the read instruction sequence.
// ****************************************************************
module srs_device_end (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Serial bus.
  srs_bus_if.device        bus,
  // Memory preload.
  input  wire logic        memLoad,
  input  wire logic [10:0] memLoadAddr,
  input  wire logic [7:0]  memLoadData,
  // Wiper sources seen at the top location.
  input  wire logic        volatileOnlySelect,
  input  wire logic [7:0]  wiperPositionRegister,
  input  wire logic [7:0]  nonvolatileWiperStore,
  // Status.
  output logic             readActive,
  output logic [10:0]      pointer,
  output logic             byteSent
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [srs_pkg::MEM_BYTES-1:0][7:0] mem;
    srs_pkg::srs_dev_state_t            st;
    logic                               sclQ;
    logic                               sdaQ;
    logic [3:0]                         bitCnt;
    logic [7:0]                         shift;
    logic [7:0]                         addrLow;
    logic [2:0]                         upper;
    logic [10:0]                        ptr;
    logic                               dir;
    logic                               gotAddr;
    logic                               acked;
    logic                               sdaOe;
    logic                               active;
    logic                               sent;
  } srs_dev_t;

  srs_dev_t r;
  srs_dev_t next_r;

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // ****************************************************************
  // Decoding.
  // ****************************************************************

  // The top location is not memory but one of the two wiper values.
  function automatic logic [7:0] readByte(input logic [10:0] loc);
    if (loc == srs_pkg::WIPER_LOC) begin
      readByte = volatileOnlySelect ? wiperPositionRegister
                                    : nonvolatileWiperStore;
    end else begin
      readByte = r.mem[loc];
    end
  endfunction

  // True when a byte carries the identification prefix.
  function automatic logic isId(input logic [7:0] b);
    isId = (b[7:4] == srs_pkg::ID_PREFIX);
  endfunction

  // Lines are synchronous inputs, so one stored sample finds edges.
  // START and STOP are the only changes of data while the clock is
  // high; the master never moves data there otherwise.
  assign sclRise   = !r.sclQ && bus.scl;
  assign sclFall   = r.sclQ && !bus.scl;
  assign startSeen = r.sclQ && bus.scl && r.sdaQ && !bus.sda;
  assign stopSeen  = r.sclQ && bus.scl && !r.sdaQ && bus.sda;

  // ****************************************************************
  // Next state.
  // ****************************************************************

  // One process walks the byte sequence on the serial clock edges.
  always_comb begin
    next_r      = r;
    next_r.sclQ = bus.scl;
    next_r.sdaQ = bus.sda;
    next_r.sent = 1'b0;
    if (memLoad) begin
      next_r.mem[memLoadAddr] = memLoadData;
    end
    if (startSeen) begin
      // A START, first or repeated, always restarts byte reception.
      next_r.st     = srs_pkg::DEV_RXID;
      next_r.bitCnt = 4'h0;
      next_r.sdaOe  = 1'b0;
      next_r.active = 1'b0;
    end else if (stopSeen) begin
      next_r.st      = srs_pkg::DEV_IDLE;
      next_r.sdaOe   = 1'b0;
      next_r.active  = 1'b0;
      next_r.gotAddr = 1'b0;
    end else begin
      case (r.st)
        srs_pkg::DEV_IDLE: begin
          next_r.sdaOe = 1'b0;
        end
        srs_pkg::DEV_RXID, srs_pkg::DEV_RXADDR: begin
          if (sclRise) begin
            next_r.shift  = {r.shift[6:0], bus.sda};
            next_r.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == srs_pkg::ACK_SLOT) begin
            next_r.bitCnt = 4'h0;
            if (r.st == srs_pkg::DEV_RXADDR) begin
              next_r.addrLow = r.shift;
              next_r.gotAddr = 1'b1;
              next_r.sdaOe   = 1'b1;
              next_r.st      = srs_pkg::DEV_ACKOUT;
            end else if (isId(r.shift)) begin
              next_r.upper = r.shift[3:1];
              next_r.dir   = r.shift[0];
              next_r.sdaOe = 1'b1;
              next_r.st    = srs_pkg::DEV_ACKOUT;
              if (r.shift[0] == srs_pkg::DIR_READ) begin
                next_r.ptr = {r.shift[3:1], r.addrLow};
              end
            end else begin
              // A foreign prefix is not ours: stay off the bus.
              next_r.st = srs_pkg::DEV_IDLE;
            end
          end
        end
        srs_pkg::DEV_ACKOUT: begin
          if (sclFall) begin
            next_r.sdaOe = 1'b0;
            if (r.dir == srs_pkg::DIR_READ) begin
              // First data bit goes out on the same falling edge.
              next_r.shift  = readByte(r.ptr);
              next_r.sdaOe  = !next_r.shift[7];
              next_r.bitCnt = 4'h1;
              next_r.ptr    = r.ptr + 11'h001;
              next_r.active = 1'b1;
              next_r.st     = srs_pkg::DEV_TX;
            end else if (!r.gotAddr) begin
              next_r.st = srs_pkg::DEV_RXADDR;
            end else begin
              // Address held; wait for the repeated START.
              next_r.st = srs_pkg::DEV_IDLE;
            end
          end
        end
        srs_pkg::DEV_TX: begin
          if (sclFall) begin
            if (r.bitCnt == srs_pkg::ACK_SLOT) begin
              next_r.sdaOe = 1'b0;
              next_r.sent  = 1'b1;
              next_r.st    = srs_pkg::DEV_ACKIN;
            end else begin
              next_r.shift  = {r.shift[6:0], 1'b0};
              next_r.sdaOe  = !r.shift[6];
              next_r.bitCnt = r.bitCnt + 4'h1;
            end
          end
        end
        srs_pkg::DEV_ACKIN: begin
          if (sclRise) begin
            next_r.acked = !bus.sda;
          end else if (sclFall) begin
            if (r.acked) begin
              next_r.shift  = readByte(r.ptr);
              next_r.sdaOe  = !next_r.shift[7];
              next_r.bitCnt = 4'h1;
              next_r.ptr    = r.ptr + 11'h001;
              next_r.st     = srs_pkg::DEV_TX;
            end else begin
              // Line stays released until STOP or a new START.
              next_r.sdaOe  = 1'b0;
              next_r.active = 1'b0;
              next_r.st     = srs_pkg::DEV_IDLE;
            end
          end
        end
        default: begin
          next_r.st    = srs_pkg::DEV_IDLE;
          next_r.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************

  // Memory contents also clear at reset, standing in for power-up.
  always_ff @(posedge clock) begin
    if (rst) begin
      r      <= '0;
      r.st   <= srs_pkg::DEV_IDLE;
      r.sclQ <= 1'b1;
      r.sdaQ <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************

  // All outputs are plain state bits.
  assign bus.deviceSdaOe = r.sdaOe;
  assign readActive      = r.active;
  assign pointer         = r.ptr;
  assign byteSent        = r.sent;

endmodule

// ---- tb/srs_bus_checker.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Bus checker: framing and handshakes seen on the two wires.
// ****************************************************************
module srs_bus_checker (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Bus lines and enables.
  input wire logic masterSclOe,
  input wire logic masterSdaOe,
  input wire logic deviceSdaOe,
  input wire logic scl,
  input wire logic sda
);
  localparam int HIGH_LEN = 2 * srs_pkg::QUARTER_CYCLES;
  localparam int STOP_MAX = 8 * srs_pkg::QUARTER_CYCLES;
  logic        sclQ, sdaQ, inFrame, repeated, readMode, sawStart;
  logic [3:0]  bitCnt, byteIdx;
  logic [7:0]  sh, firstId;
  logic [15:0] highCnt, waitStop;
  wire         rise  = scl & ~sclQ;
  wire         start = scl & sclQ & sdaQ & ~sda;
  wire         stop  = scl & sclQ & ~sdaQ & sda;
  wire         nack  = rise & readMode & (byteIdx != 4'h0) &
                       (bitCnt == 4'h8) & sda;

  // Counters replace long repetitions, which would slow the tools.
  always_ff @(posedge clock) begin
    sclQ <= scl;
    sdaQ <= sda;
    highCnt <= scl ? highCnt + 16'h0001 : 16'h0000;
    sawStart <= start | (sawStart & scl);
    if (rst) begin
      inFrame <= 1'b0;
      readMode <= 1'b0;
      waitStop <= 16'h0000;
    end else begin
      if (nack) waitStop <= 16'h0001;
      else if (stop) waitStop <= 16'h0000;
      else if (waitStop != 16'h0000) waitStop <= waitStop + 16'h0001;
      if (start) begin
        bitCnt <= 4'h0;
        byteIdx <= 4'h0;
        readMode <= 1'b0;
        repeated <= inFrame;
        inFrame <= 1'b1;
      end else if (stop) begin
        inFrame <= 1'b0;
      end else if (rise) begin
        bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
        if (bitCnt != 4'h8) sh <= {sh[6:0], sda};
        if (bitCnt == 4'h8) byteIdx <= byteIdx + 4'h1;
        if (bitCnt == 4'h8 && byteIdx == 4'h0) readMode <= sh[0];
        if (bitCnt == 4'h8 && byteIdx == 4'h0 && !repeated) firstId <= sh;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_ack(logic [3:0] idx);
    rise && bitCnt == 4'h8 && byteIdx == idx;
  endsequence

  a_id_ack: assert property (s_ack(4'h0) |-> deviceSdaOe)
    else $error("Identification byte not acknowledged");
  a_addr_ack: assert property (s_ack(4'h1) |-> readMode || deviceSdaOe)
    else $error("Address byte not acknowledged");
  a_first_dir: assert property (s_ack(4'h0) |-> repeated || !sh[0])
    else $error("First identification byte not a write");
  a_read_id: assert property (s_ack(4'h0) |->
    !repeated || sh == {firstId[7:1], 1'b1})
    else $error("Second identification byte differs");
  a_data_release: assert property (rise && readMode &&
    byteIdx != 4'h0 && waitStop == 16'h0000 |->
    ((bitCnt == 4'h8) ? !deviceSdaOe : !masterSdaOe))
    else $error("Wrong party drives data line in read");
  a_nack_quiet: assert property (waitStop != 16'h0000 |-> !deviceSdaOe)
    else $error("Device drives after missing acknowledge");
  a_stop_bound: assert property (int'(waitStop) <= STOP_MAX)
    else $error("No stop after missing acknowledge");
  a_sda_stable: assert property (scl && $past(scl) |->
    $stable(deviceSdaOe))
    else $error("Device changed data line while clock high");
  a_scl_high: assert property ($fell(scl) && !sawStart |->
    highCnt == 16'(HIGH_LEN))
    else $error("Serial clock high time wrong");
endmodule

// ---- tb/test_serial_memory_read_sequencer.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Bench: one sequential read that wraps past the top location.
// ****************************************************************
module test_serial_memory_read_sequencer;
  localparam int LIMIT = 100000;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        memLoad = 1'b0;
  logic        volatileOnlySelect = 1'b0;
  logic [7:0]  memLoadData = 8'h00;
  logic [7:0]  wiperPositionRegister = 8'h00;
  logic [7:0]  nonvolatileWiperStore = 8'h00;
  logic        reqValid = 1'b0;
  logic [10:0] reqAddr = 11'h000;
  logic [7:0]  reqLen = 8'h00;
  logic        dataReady = 1'b0;
  logic        readActive, byteSent, busy, done, nackSeen, dataValid;
  logic [10:0] pointer;
  logic [7:0]  data, wiperVal, memVal;
  logic [7:0]  expQ[$];
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          sentCount = 0;

  srs_bus_if srs_bus_if_i ();
  srs_device_end srs_device_end_i (.clock(clock), .rst(rst),
    .bus(srs_bus_if_i.device), .memLoad(memLoad),
    .memLoadAddr(11'h000), .memLoadData(memLoadData),
    .volatileOnlySelect(volatileOnlySelect),
    .wiperPositionRegister(wiperPositionRegister),
    .nonvolatileWiperStore(nonvolatileWiperStore),
    .readActive(readActive), .pointer(pointer), .byteSent(byteSent));
  srs_master_end srs_master_end_i (.clock(clock), .rst(rst),
    .bus(srs_bus_if_i.master), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqLen(reqLen), .busy(busy), .done(done), .nackSeen(nackSeen),
    .dataValid(dataValid), .data(data), .dataReady(dataReady));
  srs_bus_checker srs_bus_checker_i (.clock(clock), .rst(rst),
    .masterSclOe(srs_bus_if_i.masterSclOe),
    .masterSdaOe(srs_bus_if_i.masterSdaOe),
    .deviceSdaOe(srs_bus_if_i.deviceSdaOe),
    .scl(srs_bus_if_i.scl), .sda(srs_bus_if_i.sda));

  // Free running clock, 8 ns period.
  always #4 clock = ~clock;

  task automatic check(input string what, input logic [10:0] seen,
                       input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Pops are compared with the oldest note; stalls come at random.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    dataReady <= ($urandom % 4) != 0;
    if (byteSent === 1'b1) sentCount <= sentCount + 1;
    if (rst === 1'b0 && dataValid === 1'b1 && dataReady === 1'b1) begin
      if (expQ.size() == 0) check("extra", 11'h001, 11'h000);
      else check("data", {3'h0, data}, {3'h0, expQ.pop_front()});
    end
    if (cycles == LIMIT) begin
      errors++;
      $display("MISMATCH timeout expected done seen none");
      complete_run();
    end
  end

  // The top location reads the selected wiper, then the pointer wraps
  // to zero; the store holds the inverse so a wrong source shows.
  initial begin
    void'($urandom(86097));
    wiperVal = 8'($urandom);
    memVal = 8'($urandom);
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    memLoad <= 1'b1;
    memLoadData <= memVal;
    wiperPositionRegister <= wiperVal;
    volatileOnlySelect <= 1'($urandom);
    nonvolatileWiperStore <= ~wiperVal;
    @(posedge clock);
    memLoad <= 1'b0;
    reqValid <= 1'b1;
    reqAddr <= 11'h7ff;
    reqLen <= 8'h01;
    expQ.push_back(volatileOnlySelect ? wiperVal : ~wiperVal);
    expQ.push_back(memVal);
    @(posedge clock);
    reqAddr <= 11'h123;
    reqLen <= 8'h05;
    @(posedge clock);
    reqValid <= 1'b0;
    check("busy", {10'h000, busy}, 11'h001);
    while (done !== 1'b1) @(posedge clock);
    check("nack", {10'h000, nackSeen}, 11'h000);
    while (expQ.size() != 0) @(posedge clock);
    @(posedge clock);
    check("pointer", pointer, 11'h001);
    check("sent", 11'(sentCount), 11'h002);
    check("active", {10'h000, readActive}, 11'h000);
    complete_run();
  end
endmodule
